// ---- core/atten_cfg.svh ----
`ifndef ATTEN_CFG_SVH
`define ATTEN_CFG_SVH
`define WORD_BITS 5
`define MSB_POS 4
`define LSB_POS 0
`define WORD_RESET 5'h00
`define HALF_SCALE_MAX 6'h1F
`define SER_CLK_DIV 16'h0010
`define STRAP_SETTLE 2'h2
`define HALF_DB_UNIT 6'h01
`endif

// ---- core/atten_device.sv ----
`timescale 1ns/1ps
`include "atten_cfg.svh"
module atten_device (
  input  wire logic      clk,
  input  wire logic      arst_n,
  atten_link_if.device_end link,
  input  wire logic      step_sel_8db,
  input  wire logic      step_sel_4db,
  input  wire logic      step_sel_2db,
  input  wire logic      step_sel_1db,
  input  wire logic      step_sel_half_db,
  output atten_pkg::word_type ctrl_bits,
  output logic [5:0]     atten_half_db
);
  import atten_pkg::*;

  logic       clk_meta_reg;
  logic       clk_sync_reg;
  logic       clk_prev_reg;
  logic       rise;

  logic       dat_meta_reg;
  logic       dat_sync_reg;

  logic       le_meta_reg;
  logic       le_sync_reg;
  logic       le_prev_reg;
  logic       le_fall;
  logic       latch_open;

  word_type   straps;
  logic [1:0] settle_cnt_reg;
  logic       pwr_done_reg;
  logic       pwr_load;

  word_type   shift_in;
  word_type   shift_word;
  word_type   latch_word;

  logic [5:0] part_sum [0:`WORD_BITS];
  logic [5:0] atten_next;
  logic [5:0] atten_reg;

  ////////////////////////////////////////////////////////////////////////
  // Link pins come from another domain, so two flops before any use.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_meta_reg <= 1'b0;
      clk_sync_reg <= 1'b0;
    end else begin
      clk_meta_reg <= link.ser_clk;
      clk_sync_reg <= clk_meta_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dat_meta_reg <= 1'b0;
      dat_sync_reg <= 1'b0;
    end else begin
      dat_meta_reg <= link.ser_data;
      dat_sync_reg <= dat_meta_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      le_meta_reg <= 1'b0;
      le_sync_reg <= 1'b0;
    end else begin
      le_meta_reg <= link.latch_strobe;
      le_sync_reg <= le_meta_reg;
    end
  end

  // Both edge detectors reset to the idle low level of their pins, so reset makes no edge.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_prev_reg <= 1'b0;
      le_prev_reg  <= 1'b0;
    end else begin
      clk_prev_reg <= clk_sync_reg;
      le_prev_reg  <= le_sync_reg;
    end
  end

  assign rise    = clk_sync_reg & ~clk_prev_reg;
  assign le_fall = le_prev_reg & ~le_sync_reg;

  ////////////////////////////////////////////////////////////////////////
  // Straps are pins as well, so they are taken only once their synchronisers have settled.
  assign straps = {step_sel_8db,
                   step_sel_4db,
                   step_sel_2db,
                   step_sel_1db,
                   step_sel_half_db};

  // The count stops at its end, so the straps are taken once per reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt_reg <= 2'h0;
    end else if (settle_cnt_reg != `STRAP_SETTLE) begin
      settle_cnt_reg <= settle_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_done_reg <= 1'b0;
    end else if (pwr_load) begin
      pwr_done_reg <= 1'b1;
    end
  end

  // A reset in mid-run takes the straps again, as a power cycle would.
  assign pwr_load    = (settle_cnt_reg == `STRAP_SETTLE) && !pwr_done_reg;
  assign latch_open  = (le_sync_reg | le_fall) & pwr_done_reg;
  assign part_sum[0] = 6'h00;

  ////////////////////////////////////////////////////////////////////////
  // One slice per control bit: strap sync, shift stage, latch and step weight.
  for (genvar i = 0; i < `WORD_BITS; i++) begin : bit_gen
    logic       strap_meta_reg;
    logic       strap_sync_reg;
    logic       stage_reg;
    logic       hold_reg;
    logic       hold_next;
    logic [5:0] step_weight;

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        strap_meta_reg <= 1'b0;
        strap_sync_reg <= 1'b0;
      end else begin
        strap_meta_reg <= straps[i];
        strap_sync_reg <= strap_meta_reg;
      end
    end

    if (i == `LSB_POS) begin : first_stage
      assign shift_in[i] = dat_sync_reg;
    end else begin : later_stage
      assign shift_in[i] = shift_word[i - 1];
    end

    // Shifting never looks at the strobe.
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        stage_reg <= 1'b0;
      end else if (rise) begin
        stage_reg <= shift_in[i];
      end
    end

    // The strap load wins, so a strobe during settling cannot spoil the power-up word.
    always_comb begin
      hold_next = hold_reg;
      if (pwr_load) begin
        hold_next = strap_sync_reg;
      end else if (latch_open) begin
        hold_next = stage_reg;
      end
    end

    // A closed latch keeps its flop, so the word stands until the next strobe.
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        hold_reg <= 1'b0;
      end else begin
        hold_reg <= hold_next;
      end
    end

    assign step_weight     = `HALF_DB_UNIT << i;
    assign part_sum[i + 1] = part_sum[i] + (hold_next ? step_weight : 6'h00);
    assign shift_word[i]   = stage_reg;
    assign latch_word[i]   = hold_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // The sum is registered beside the latch, so both outputs move in the same cycle.
  assign atten_next = part_sum[`WORD_BITS];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      atten_reg <= 6'h00;
    end else begin
      atten_reg <= atten_next;
    end
  end

  assign ctrl_bits     = latch_word;
  assign atten_half_db = atten_reg;
endmodule

// ---- core/atten_host.sv ----
`timescale 1ns/1ps
`include "atten_cfg.svh"
module atten_host (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              start,
  input  wire atten_pkg::word_type word_in,
  output logic                   busy,
  atten_link_if.host_end         link
);
  import atten_pkg::*;

  logic [15:0]    div_reg;
  logic           tick;
  host_state_type state_reg;
  word_type       word_reg;
  logic [2:0]     cnt_reg;
  logic           phase_reg;
  logic           sclk_reg;
  logic           sdat_reg;
  logic           le_reg;

  ////////////////////////////////////////////////////////////////////////
  assign tick = (div_reg == `SER_CLK_DIV - 16'h0001);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 16'h0000;
    end else if (tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Each tick advances one third of a serial clock period: clock low for two ticks, high for one.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= HOST_IDLE;
      word_reg  <= `WORD_RESET;
      cnt_reg   <= 3'h0;
      phase_reg <= 1'b0;
      sclk_reg  <= 1'b0;
      sdat_reg  <= 1'b0;
      le_reg    <= 1'b0;
    end else begin
      case (state_reg)
        HOST_IDLE: begin
          le_reg <= 1'b0;
          if (start) begin
            word_reg  <= word_in;
            cnt_reg   <= 3'h0;
            phase_reg <= 1'b0;
            state_reg <= HOST_SHIFT;
          end
        end
        HOST_SHIFT: if (tick) begin
          if (!phase_reg) begin
            // Data is set while the clock is low, well ahead of the rise.
            sdat_reg  <= word_reg[`MSB_POS];
            sclk_reg  <= 1'b0;
            phase_reg <= 1'b1;
          end else begin
            sclk_reg  <= ~sclk_reg;
            if (sclk_reg) begin
              // Falling edge; data held until here.
              word_reg  <= {word_reg[3:0], 1'b0};
              phase_reg <= 1'b0;
              if (cnt_reg == 3'h4) begin
                state_reg <= HOST_LATCH;
              end else begin
                cnt_reg <= cnt_reg + 3'h1;
              end
            end
          end
        end
        HOST_LATCH: if (tick) begin
          le_reg    <= 1'b1;
          state_reg <= HOST_DONE;
        end
        HOST_DONE: if (tick) begin
          le_reg    <= 1'b0;
          state_reg <= HOST_IDLE;
        end
        default: state_reg <= HOST_IDLE;
      endcase
    end
  end

  assign busy              = (state_reg != HOST_IDLE);
  assign link.ser_clk      = sclk_reg;
  assign link.ser_data     = sdat_reg;
  assign link.latch_strobe = le_reg;
endmodule

// ---- core/atten_link_if.sv ----
`timescale 1ns/1ps
interface atten_link_if;
  logic ser_clk;
  logic ser_data;
  logic latch_strobe;
  modport device_end (input ser_clk, input ser_data, input latch_strobe);
  modport host_end (output ser_clk, output ser_data, output latch_strobe);
endinterface

// ---- core/atten_pkg.sv ----
package atten_pkg;
  typedef logic [4:0] word_type;
  typedef enum logic [3:0] {
    HOST_IDLE  = 4'b0001,
    HOST_SHIFT = 4'b0010,
    HOST_LATCH = 4'b0100,
    HOST_DONE  = 4'b1000
  } host_state_type;
endpackage

// ---- testbench/atten_link_checker.sv ----
`timescale 1ns/1ps
module atten_link_checker (
  input wire logic                clk,
  input wire logic                arst_n,
  input wire logic                ser_clk,
  input wire logic                ser_data,
  input wire logic                latch_strobe,
  input wire atten_pkg::word_type ctrl_bits,
  input wire logic [5:0]          atten_half_db
);
  import atten_pkg::*;
  word_type   sreg;
  logic [5:0] weighted_sum;
  assign weighted_sum = 6'h10 * ctrl_bits[4] + 6'h08 * ctrl_bits[3] + 6'h04 * ctrl_bits[2]
                      + 6'h02 * ctrl_bits[1] + 6'h01 * ctrl_bits[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////
  // A private copy of the wire word, so the latch is judged apart from the device.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) sreg <= 5'h0;
    else if ($rose(ser_clk)) sreg <= {sreg[3:0], ser_data};
  end
  sequence pulse_s;
    latch_strobe[*8] ##[9:20] !latch_strobe;
  endsequence
  a_strobe_low_shift: assert property ($rose(ser_clk) |-> !latch_strobe)
    else $error("strobe high at shift");
  a_strobe_pulse: assert property ($rose(latch_strobe) |-> pulse_s)
    else $error("bad strobe pulse");
  a_late_strobe: assert property ($rose(latch_strobe) |-> !ser_clk && !$past(ser_clk, 8))
    else $error("strobe too early");
  a_data_steady: assert property (ser_clk |-> $stable(ser_data))
    else $error("data moved while clock high");
  a_clock_high: assert property ($rose(ser_clk) |-> ser_clk[*8])
    else $error("short clock high");
  a_latch_open: assert property (latch_strobe[*6] |-> ctrl_bits == sreg)
    else $error("latch not transparent");
  a_latch_hold: assert property (!latch_strobe[*6] |-> $stable(ctrl_bits))
    else $error("latch not holding");
  a_weight_sum: assert property ($stable(ctrl_bits) |-> atten_half_db == weighted_sum)
    else $error("attenuation sum wrong");
endmodule

// ---- testbench/serial_attenuation_word_latch_tb_top.sv ----
`timescale 1ns/1ps
module serial_attenuation_word_latch_tb_top;
  import atten_pkg::*;
  logic       clk = 0, arst_n = 0, start = 0, busy;
  word_type   word_in = 5'h0, straps = 5'h15, ctrl_bits, wire_word;
  logic [5:0] atten_half_db;
  int         bad_count = 0, n_tests = 0;
  word_type   words[5] = '{5'h10, 5'h01, 5'h1F, 5'h00, 5'h0A};
  always #10 clk = ~clk;
  atten_link_if atten_link_if_i ();
  atten_host atten_host_i (.clk(clk), .arst_n(arst_n), .start(start), .word_in(word_in),
    .busy(busy), .link(atten_link_if_i.host_end));
  atten_device atten_device_i (.clk(clk), .arst_n(arst_n), .link(atten_link_if_i.device_end),
    .step_sel_8db(straps[4]), .step_sel_4db(straps[3]), .step_sel_2db(straps[2]),
    .step_sel_1db(straps[1]), .step_sel_half_db(straps[0]), .ctrl_bits(ctrl_bits),
    .atten_half_db(atten_half_db));
  atten_link_checker atten_link_checker_i (.clk(clk), .arst_n(arst_n),
    .ser_clk(atten_link_if_i.ser_clk), .ser_data(atten_link_if_i.ser_data),
    .latch_strobe(atten_link_if_i.latch_strobe), .ctrl_bits(ctrl_bits),
    .atten_half_db(atten_half_db));
  always @(posedge atten_link_if_i.ser_clk) wire_word <= {wire_word[3:0], atten_link_if_i.ser_data};
  ////////////////////////////////////////////////////////////
  task automatic check(string n, logic [5:0] s, logic [5:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // A second start mid-word must be ignored, so every word also probes refusal.
  task automatic send(word_type w);
    int k;
    word_type old;
    old = ctrl_bits;
    @(posedge clk);
    start <= 1'b1;
    word_in <= w;
    @(posedge clk) start <= 1'b0;
    repeat (10) @(posedge clk);
    start <= 1'b1;
    word_in <= ~w;
    @(posedge clk) start <= 1'b0;
    repeat (70) @(posedge clk);
    #1 check("hold", {1'b0, ctrl_bits}, {1'b0, old});
    for (k = 0; busy === 1'b1 && k < 400; k++) @(posedge clk) #1;
    if (k == 400) begin
      bad_count++;
      conclude();
    end
    repeat (8) @(posedge clk);
    #1 check("ctrl", {1'b0, ctrl_bits}, {1'b0, w});
    check("sum", atten_half_db, 6'(w[4] * 16 + w[3] * 8 + w[2] * 4 + w[1] * 2 + w[0]));
    check("wire", {1'b0, wire_word}, {1'b0, w});
    check("strobe", {5'h0, atten_link_if_i.latch_strobe}, 6'h0);
    $display("send %h done", w);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("strap", {1'b0, ctrl_bits}, 6'h15);
    check("strapsum", atten_half_db, 6'h15);
    $display("power-up done");
    foreach (words[i]) send(words[i]);
    @(posedge clk);
    arst_n <= 1'b0;
    straps <= 5'h13;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("restrap", {1'b0, ctrl_bits}, 6'h13);
    check("restrapsum", atten_half_db, 6'h13);
    $display("reset done");
    conclude();
  end
endmodule
